// *** hw/cprr_readout.sv ***
// Purpose: serial read-out of stored configuration revisions towards an FPGA
// Assumes: storage answers mem_data_i combinationally for mem_addr_o
// Notes: all pins pass two flip-flops; link clock edges are found by sampling
`timescale 1ns/100ps

module cprr_readout #(
	parameter int BLOCK_LOG2 = cprr_pkg::BLOCK_LOG2_DEF,
	parameter int BLK_W = cprr_pkg::BLK_W_DEF,
	parameter int MEM_BLOCKS = cprr_pkg::MEM_BLOCKS_DEF,
	parameter int OSC_DIV = cprr_pkg::OSC_DIV_DEF,
	parameter int DECOMP_DIV = cprr_pkg::DECOMP_DIV_DEF
)(
	input wire logic clk_i,
	input wire logic reset_i,
	// register bus
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// storage read port
	output logic [BLK_W+BLOCK_LOG2-1:0] mem_addr_o,
	input wire logic mem_data_i,
	input wire logic mem_valid_i,
	// configuration pins
	input wire logic chip_enable_n_i,
	input wire logic output_enable_reset_i,
	input wire logic configuration_clock_i,
	input wire logic clock_pin_i,
	input wire logic busy_i,
	input wire logic external_select_enable_i,
	input wire logic [1:0] revision_select_pins_i,
	input wire logic configuration_trigger_i,
	output logic configuration_trigger_o,
	output logic configuration_trigger_oe_o,
	output logic data_o,
	output logic data_oe_o,
	output logic source_clock_output_o,
	output logic source_clock_output_oe_o,
	output logic chain_enable_output_n_o
);
	import cprr_pkg::*;

	localparam int AW = BLK_W + BLOCK_LOG2;
	localparam logic [BLK_W:0] MEM_END = (BLK_W + 1)'(MEM_BLOCKS);
	localparam logic [7:0] OSC_LIM = 8'(OSC_DIV - 1);
	localparam logic [7:0] DEC_LIM = 8'(DECOMP_DIV - 1);

	function automatic logic [1:0] sel_rev(input logic ext, input logic [1:0] pins, input logic [1:0] bits);
		sel_rev = ext ? bits : pins;
	endfunction

	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
		be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [NSYNC-1:0] pin_vec;
	logic [NSYNC-1:0] sync0_q;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] prev_q;

	assign pin_vec = {revision_select_pins_i, external_select_enable_i, configuration_trigger_i, busy_i,
		clock_pin_i, configuration_clock_i, output_enable_reset_i, chip_enable_n_i};

	for (genvar g = 0; g < NSYNC; g++)
	begin : g_sync
		always_ff @(posedge clk_i)
		begin
			if (reset_i)
			begin
				sync0_q[g] <= SYNC_RST[g];
				sync1_q[g] <= SYNC_RST[g];
				prev_q[g] <= SYNC_RST[g];
			end
			else
			begin
				sync0_q[g] <= pin_vec[g];
				sync1_q[g] <= sync0_q[g];
				prev_q[g] <= sync1_q[g];
			end
		end
	end

	wire ce_act = ~sync1_q[IX_CE_N];
	wire oe_s = sync1_q[IX_OE];
	wire busy_s = sync1_q[IX_BUSY];
	wire ext_s = sync1_q[IX_EXT];
	wire [1:0] pins_s = sync1_q[IX_PINS+1:IX_PINS];
	wire configuration_clock_rise = sync1_q[IX_CONFIGURATION_CLOCK] & ~prev_q[IX_CONFIGURATION_CLOCK];
	wire pin_rise = sync1_q[IX_CLKPIN] & ~prev_q[IX_CLKPIN];
	wire trig_rise = sync1_q[IX_TRIG] & ~prev_q[IX_TRIG];

	////////////////////////////////////////////////////////////////////////////
	// register bus

	logic [4:0] ctrl_q;
	logic [15:0] rev_tab_q [NUM_REVS];
	logic wait_q;
	logic [31:0] rdata_q;
	logic [5:0] trig_cnt_q;
	logic trig_lvl_q;
	logic trig_oe_q;
	logic [1:0] rev_q;
	logic [AW-1:0] addr_q;
	cprr_state_e state_q;
	logic source_clock_output_q;
	logic source_clock_output_oe_q;

	wire [5:0] word = {avs_address_i[5:2], 2'h0};
	wire req = avs_read_i | avs_write_i;
	// one wait cycle: data is loaded on the first edge, handed over on the second
	wire prep = req & wait_q;
	wire take_wr = avs_write_i & ~wait_q;
	wire is_rev = word[5:4] == OFF_REV0[5:4];
	wire [1:0] rev_ix = word[3:2];
	wire decomp = ctrl_q[CTRL_DECOMP];
	wire source_clock_output_en = ctrl_q[CTRL_SOURCE_CLOCK_OUTPUT_EN] | decomp;
	wire osc_sel = ctrl_q[CTRL_OSC_SEL];
	wire [31:0] status_w = {27'h0, state_q == ST_RUN, source_clock_output_oe_q, state_q == ST_DONE, rev_q};
	wire [31:0] info_w = {16'h0, 8'(BLOCK_LOG2), 8'(MEM_BLOCKS)};
	wire [31:0] rd_mux = (word == OFF_CTRL) ? {27'h0, ctrl_q} :
		(word == OFF_STATUS) ? status_w :
		(word == OFF_ADDR) ? 32'(addr_q) :
		(word == OFF_INFO) ? info_w :
		is_rev ? {16'h0, rev_tab_q[rev_ix]} : 32'h0;
	wire trig_start = take_wr & (word == OFF_CTRL) & avs_byteenable_i[0] & avs_writedata_i[CTRL_TRIG];

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end
		else
		begin
			wait_q <= ~prep;
			rdata_q <= prep ? rd_mux : rdata_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ctrl_q <= CTRL_RST;
		else if (take_wr & (word == OFF_CTRL) & avs_byteenable_i[0])
			ctrl_q <= avs_writedata_i[4:0];
	end

	for (genvar r = 0; r < NUM_REVS; r++)
	begin : g_rev
		always_ff @(posedge clk_i)
		begin
			if (reset_i)
				rev_tab_q[r] <= REV_RST[r];
			else if (take_wr & is_rev & (rev_ix == 2'(r)))
				rev_tab_q[r] <= be_merge(rev_tab_q[r], avs_writedata_i[15:0], avs_byteenable_i[1:0]);
		end
	end

	assign avs_waitrequest_o = wait_q;
	assign avs_readdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// trigger pin: software pulses it low, released it idles high

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			trig_cnt_q <= 6'h0;
		else if (trig_start)
			trig_cnt_q <= TRIG_CYC;
		else if (trig_cnt_q != 6'h0)
			trig_cnt_q <= trig_cnt_q - 6'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			trig_oe_q <= 1'b0;
			trig_lvl_q <= 1'b1;
		end
		else
		begin
			trig_oe_q <= trig_start | (trig_cnt_q > 6'h1);
			trig_lvl_q <= ~(trig_start | (trig_cnt_q > 6'h1));
		end
	end

	assign configuration_trigger_o = trig_lvl_q;
	assign configuration_trigger_oe_o = trig_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// revision selection and address sequencing

	logic [1:0] init_cnt_q;
	logic [1:0] rev_d;
	logic [AW-1:0] addr_d;
	cprr_state_e state_d;

	wire [1:0] samp_rev = sel_rev(ext_s, pins_s, ctrl_q[CTRL_REV_LSB+1:CTRL_REV_LSB]);
	wire [BLK_W-1:0] samp_first = rev_tab_q[samp_rev][REV_FIRST_LSB+BLK_W-1:REV_FIRST_LSB];
	wire [BLK_W-1:0] cur_first = rev_tab_q[rev_q][REV_FIRST_LSB+BLK_W-1:REV_FIRST_LSB];
	wire [BLK_W-1:0] cur_count = rev_tab_q[rev_q][REV_COUNT_LSB+BLK_W-1:REV_COUNT_LSB];
	wire [BLK_W:0] rev_end = {1'b0, cur_first} + {1'b0, cur_count};
	// the part beyond this memory belongs to the next one in the chain
	wire [BLK_W:0] end_blk = (rev_end > MEM_END) ? MEM_END : rev_end;
	wire [AW:0] next_addr = {1'b0, addr_q} + (AW + 1)'(1);
	wire at_last = next_addr == {end_blk, {BLOCK_LOG2{1'b0}}};

	// clock output generation
	logic [7:0] div_cnt_q;
	wire [7:0] div_lim = decomp ? DEC_LIM : OSC_LIM;
	wire tick = osc_sel ? (div_cnt_q == div_lim) : pin_rise;
	wire ready = ~decomp | mem_valid_i;
	wire drive_clk = source_clock_output_en & ce_act & oe_s & (state_q == ST_RUN);
	// the output only falls when a bit is ready, so every rise it makes carries data
	wire out_fall = drive_clk & tick & source_clock_output_q & ready;
	wire out_rise = drive_clk & tick & ~source_clock_output_q;
	wire parked = decomp & ~mem_valid_i & source_clock_output_q;
	wire step = source_clock_output_en ? out_rise : configuration_clock_rise;
	wire adv = step & ce_act & oe_s & (decomp | ~busy_s);

	always_comb
	begin
		state_d = state_q;
		addr_d = addr_q;
		rev_d = rev_q;
		unique case (state_q)
			ST_INIT:
			begin
				if (init_cnt_q == INIT_CYC)
				begin
					rev_d = samp_rev;
					addr_d = {samp_first, {BLOCK_LOG2{1'b0}}};
					state_d = ST_RUN;
				end
			end
			ST_RUN, ST_DONE:
			begin
				if (ce_act & trig_rise)
				begin
					rev_d = samp_rev;
					addr_d = {samp_first, {BLOCK_LOG2{1'b0}}};
					state_d = ST_RUN;
				end
				else if (~oe_s)
				begin
					addr_d = {cur_first, {BLOCK_LOG2{1'b0}}};
					state_d = ST_RUN;
				end
				else if ((state_q == ST_RUN) & adv)
				begin
					if (at_last)
						state_d = ST_DONE;
					else
						addr_d = next_addr[AW-1:0];
				end
			end
			default:
				state_d = ST_INIT;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_INIT;
			addr_q <= '0;
			rev_q <= REV_0;
			init_cnt_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			addr_q <= addr_d;
			rev_q <= rev_d;
			init_cnt_q <= (init_cnt_q == INIT_CYC) ? init_cnt_q : init_cnt_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock output

	always_ff @(posedge clk_i)
	begin
		if (reset_i | ~osc_sel | tick)
			div_cnt_q <= 8'h0;
		else
			div_cnt_q <= div_cnt_q + 8'h1;
	end

	// while parked the pin floats high under its pull-up; the register matches it
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			source_clock_output_q <= 1'b1;
			source_clock_output_oe_q <= 1'b0;
		end
		else
		begin
			source_clock_output_q <= ~drive_clk | out_rise | (source_clock_output_q & ~out_fall);
			source_clock_output_oe_q <= drive_clk & ~parked;
		end
	end

	assign source_clock_output_o = source_clock_output_q;
	assign source_clock_output_oe_o = source_clock_output_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// data and chain outputs

	logic data_q;
	logic data_oe_q;
	logic chain_n_q;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_q <= 1'b1;
			data_oe_q <= 1'b0;
			chain_n_q <= 1'b1;
		end
		else
		begin
			data_q <= (state_q == ST_RUN) ? mem_data_i : 1'b1;
			data_oe_q <= ce_act & oe_s;
			chain_n_q <= ~(ce_act & (state_q == ST_DONE));
		end
	end

	assign mem_addr_o = addr_q;
	assign data_o = data_q;
	assign data_oe_o = data_oe_q;
	assign chain_enable_output_n_o = chain_n_q;

endmodule

// *** pkg/cprr_pkg.sv ***
// Purpose: shared constants and types of the configuration read-out block
// Assumes: 125 MHz system clock, Avalon-MM register access
// Notes: offsets are byte addresses of 32-bit words
package cprr_pkg;

	// revision numbers
	localparam logic [1:0] REV_0 = 2'h0;
	localparam logic [1:0] REV_1 = 2'h1;
	localparam logic [1:0] REV_2 = 2'h2;
	localparam logic [1:0] REV_3 = 2'h3;
	localparam int NUM_REVS = 4;

	// storage geometry defaults: 8-Mbit blocks
	localparam int BLOCK_LOG2_DEF = 23;
	localparam int BLK_W_DEF = 8;
	localparam int MEM_BLOCKS_DEF = 4;
	localparam int OSC_DIV_DEF = 4;
	localparam int DECOMP_DIV_DEF = 8;

	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TRIG_PULSE_NS = 300;
	localparam logic [5:0] TRIG_CYC = 6'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] INIT_CYC = 2'h3;

	// synchroniser lanes and their reset levels
	localparam int NSYNC = 9;
	localparam int IX_CE_N = 0;
	localparam int IX_OE = 1;
	localparam int IX_CONFIGURATION_CLOCK = 2;
	localparam int IX_CLKPIN = 3;
	localparam int IX_BUSY = 4;
	localparam int IX_TRIG = 5;
	localparam int IX_EXT = 6;
	localparam int IX_PINS = 7;
	localparam logic [8:0] SYNC_RST = 9'h021;

	// register map
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_ADDR = 6'h08;
	localparam logic [5:0] OFF_INFO = 6'h0C;
	localparam logic [5:0] OFF_REV0 = 6'h10;

	// control fields
	localparam int CTRL_REV_LSB = 0;
	localparam int CTRL_SOURCE_CLOCK_OUTPUT_EN = 2;
	localparam int CTRL_DECOMP = 3;
	localparam int CTRL_OSC_SEL = 4;
	localparam int CTRL_TRIG = 5;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// revision table fields and reset contents
	localparam int REV_FIRST_LSB = 0;
	localparam int REV_COUNT_LSB = 8;
	localparam logic [15:0] REV_RST [NUM_REVS] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103};

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_RUN = 3'b010,
		ST_DONE = 3'b100
	} cprr_state_e;

endpackage

// *** sim/cprr_readout_monitor.sv ***
// Purpose: port-level checks of the revision read-out block
// Assumes: synchronous active-high reset, one clock domain
// Notes: pin-based checks allow for the two-flop input synchronisers
`timescale 1ns/100ps

module cprr_readout_monitor
	import cprr_pkg::*;
#(
	parameter int BLOCK_LOG2 = BLOCK_LOG2_DEF,
	parameter int BLK_W = BLK_W_DEF
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [BLK_W+BLOCK_LOG2-1:0] mem_addr_o,
	input wire logic chip_enable_n_i,
	input wire logic output_enable_reset_i,
	input wire logic configuration_trigger_o,
	input wire logic configuration_trigger_oe_o,
	input wire logic data_o,
	input wire logic data_oe_o,
	input wire logic source_clock_output_o,
	input wire logic source_clock_output_oe_o,
	input wire logic chain_enable_output_n_o
);
	logic [5:0] trig_cnt_q;
	logic [5:0] trig_cnt_d;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	////////////////////////////////////////
	// counts how long the trigger pin is pulled low
	assign trig_cnt_d = configuration_trigger_oe_o ? trig_cnt_q + 6'h01 : 6'h00;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			trig_cnt_q <= 6'h00;
		else
			trig_cnt_q <= trig_cnt_d;
	end

	////////////////////////////////////////
	// six cycles leave room for the synchroniser and output register
	chk_ce_data_off: assert property (chip_enable_n_i[*6] |-> !data_oe_o)
		else $error("data driven with chip enable high");
	chk_ce_clk_off: assert property (chip_enable_n_i[*6] |-> !source_clock_output_oe_o)
		else $error("clock out driven with chip enable high");
	chk_oe_addr_start: assert property (!output_enable_reset_i[*6] |-> mem_addr_o[BLOCK_LOG2-1:0] == '0)
		else $error("address not at block start in reset");
	chk_addr_step: assert property ($changed(mem_addr_o)
		|-> mem_addr_o == $past(mem_addr_o) + 1'b1 || mem_addr_o[BLOCK_LOG2-1:0] == '0)
		else $error("address moved by other than one");
	chk_done_pad: assert property ($fell(chain_enable_output_n_o) |-> data_o)
		else $error("data not padding at chain hand-over");
	chk_done_clk_off: assert property ($fell(chain_enable_output_n_o) |-> !source_clock_output_oe_o)
		else $error("clock out still driven at hand-over");
	chk_trig_level: assert property (configuration_trigger_oe_o |-> !configuration_trigger_o)
		else $error("trigger driven high");
	chk_trig_len: assert property ($fell(configuration_trigger_oe_o) |-> trig_cnt_q == TRIG_CYC)
		else $error("trigger pulse length wrong");
	chk_clk_park: assert property (!source_clock_output_oe_o |-> source_clock_output_o)
		else $error("clock out not parked high");
endmodule

// *** sim/cprr_fpga_model.sv ***
// Purpose: configuration side of the link in leader serial mode
// Assumes: link clock 80 ns, idle low outside frames
// Notes: captured bits are the data seen just before each rising edge
`timescale 1ns/100ps

module cprr_fpga_model (
	input wire logic clk_i,
	input wire logic data_i,
	output logic configuration_clock_o,
	output logic init_o,
	output logic prog_n_o
);
	logic cap [0:31];

	initial
	begin
		configuration_clock_o = 1'b0;
		init_o = 1'b1;
		prog_n_o = 1'b1;
	end

	// init low restarts the loader at its first block
	task automatic init_pulse();
		@(posedge clk_i);
		init_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		init_o <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask

	// program request pulse; the rising edge asks for a resample
	task automatic prog_pulse();
		@(posedge clk_i);
		prog_n_o <= 1'b0;
		repeat (40) @(posedge clk_i);
		prog_n_o <= 1'b1;
		repeat (10) @(posedge clk_i);
	endtask

	// this side makes the link clock, ten system clocks a period; it idles low between frames
	task automatic frame(input int n);
		for (int i = 0; i < n; i++)
		begin
			repeat (5) @(posedge clk_i);
			cap[i] = data_i;
			configuration_clock_o <= 1'b1;
			repeat (5) @(posedge clk_i);
			configuration_clock_o <= 1'b0;
		end
		// let the last edge pass the synchroniser and the address step
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// *** sim/cprr_readout_tb.sv ***
// Purpose: self-checking bench of the revision read-out block
// Assumes: blocks of 16 bits, revision n at block n
// Notes: storage content is a fixed function of the address
`timescale 1ns/100ps

module cprr_readout_tb;
	import cprr_pkg::*;
	localparam int BL2 = 4;
	logic clk_i, reset_i, rd_q, wr_q, avs_wait, ce_n, busy, ext, trig_o, trig_oe;
	logic dat, dat_oe, sco, sco_oe, chain_n, configuration_clock, init_n, prog_n, trig_w, mem_d;
	logic [1:0] pins, r, r0;
	logic [5:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [11:0] maddr;
	logic din, sclk, mvalid, cpin;
	logic [3:0] be;
	int n_errors, n_compared, b, nr;

	cprr_readout #(.BLOCK_LOG2(BL2)) u_cprr_readout (.clk_i, .reset_i,
		.avs_address_i(addr), .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(avs_wait),
		.mem_addr_o(maddr), .mem_data_i(mem_d), .mem_valid_i(mvalid), .chip_enable_n_i(ce_n),
		.output_enable_reset_i(init_n), .configuration_clock_i(configuration_clock), .clock_pin_i(cpin),
		.busy_i(busy), .external_select_enable_i(ext), .revision_select_pins_i(pins),
		.configuration_trigger_i(trig_w), .configuration_trigger_o(trig_o),
		.configuration_trigger_oe_o(trig_oe), .data_o(dat), .data_oe_o(dat_oe),
		.source_clock_output_o(sco), .source_clock_output_oe_o(sco_oe),
		.chain_enable_output_n_o(chain_n));
	cprr_fpga_model u_cprr_fpga_model (.clk_i, .data_i(din), .configuration_clock_o(configuration_clock), .init_o(init_n),
		.prog_n_o(prog_n));

	assign mem_d = ^maddr[2:0] ^ maddr[4];
	// an undriven data line shows the inverse, so a stale bit cannot pass for a good one
	assign din = dat_oe ? dat : ~dat;
	// the released clock output line floats high under its pull-up
	assign sclk = sco_oe ? sco : 1'b1;
	// wired line with pull-up: low if either side pulls it low
	assign trig_w = (trig_oe ? trig_o : 1'b1) & prog_n;

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////
	function automatic logic exp_bit(logic [1:0] rv, int i);
		logic [11:0] a;
		a = 12'({rv, 4'h0} + i);
		return (i > 15) ? 1'b1 : ^a[2:0] ^ a[4];
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// waits for the answer however long it takes; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		rd_q <= !w;
		wr_q <= w;
		addr <= a;
		wdata <= d;
		do
			@(posedge clk_i);
		while (avs_wait !== 1'b0);
		q = rdata;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask

	// follower side: one bit is taken at every rise of the clock output line
	task automatic follow(input int lim, input logic pin, input logic dec, output int n);
		logic last;
		last = 1'b1;
		n = 0;
		for (int c = 0; c < lim && chain_n; c++)
		begin
			@(posedge clk_i);
			if (pin)
				cpin <= c[2];
			if (dec)
				mvalid <= ($urandom % 4) != 0;
			if (sclk && !last)
			begin
				chk(din, exp_bit(2'h2, n));
				n++;
			end
			last = sclk;
		end
	endtask

	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		n_errors = 0;
		n_compared = 0;
		reset_i = 1'b1;
		{rd_q, wr_q, busy, ext} = 4'h0;
		be = 4'hF;
		mvalid = 1'b1;
		cpin = 1'b0;
		addr = 6'h00;
		wdata = 32'h0;
		ce_n = 1'b1;
		void'($urandom(32'hBAB6));
		r0 = 2'($urandom);
		pins = r0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rd(OFF_INFO, 32'h0404, 32'hFFFF);
		rd(OFF_REV0 + 6'h04, 32'h0101, 32'hFFFF);
		rd(6'h20, 32'h0, 32'hFFFFFFFF);
		// only the count lane is written: revision 3 now runs past the end of this memory
		be <= 4'h2;
		bus(1'b1, OFF_REV0 + 6'h0C, 32'h0000_0517);
		be <= 4'hF;
		rd(OFF_REV0 + 6'h0C, 32'h0503, 32'hFFFF);
		rd(OFF_STATUS, {30'h0, r0}, 32'h3);
		rd(OFF_ADDR, {26'h0, r0, 4'h0}, 32'hFFF);
		ce_n <= 1'b0;
		for (int k = 0; k < 5; k++)
		begin
			r = (k < 4) ? 2'(k) : 2'($urandom);
			pins <= r;
			u_cprr_fpga_model.prog_pulse();
			rd(OFF_ADDR, {26'h0, r, 4'h0}, 32'hFFF);
			u_cprr_fpga_model.init_pulse();
			pins <= ~r;
			u_cprr_fpga_model.frame(18);
			for (int i = 0; i < 18; i++)
				chk(u_cprr_fpga_model.cap[i], exp_bit(r, i));
			chk(chain_n, 1'b0);
			chk(dat_oe, 1'b1);
			rd(OFF_STATUS, {30'h0, r}, 32'h3);
		end
		ext <= 1'b1;
		pins <= 2'h1;
		bus(1'b1, OFF_CTRL, 32'h22);
		repeat (60) @(posedge clk_i);
		rd(OFF_STATUS, 32'h2, 32'h3);
		rd(OFF_CTRL, 32'h2, 32'hFFFFFFFF);
		u_cprr_fpga_model.init_pulse();
		b = $urandom % 2;
		busy <= b[0];
		u_cprr_fpga_model.frame(3);
		rd(OFF_ADDR, (b == 1) ? 32'h20 : 32'h23, 32'hFFF);
		busy <= 1'b0;
		ce_n <= 1'b1;
		u_cprr_fpga_model.frame(3);
		rd(OFF_ADDR, (b == 1) ? 32'h20 : 32'h23, 32'hFFF);
		chk(dat_oe, 1'b0);
		// clock output from the divider, then from the clock pin, then gated by decompression
		for (int m = 0; m < 3; m++)
		begin
			ce_n <= 1'b1;
			busy <= (m == 2);
			mvalid <= (m != 2);
			bus(1'b1, OFF_CTRL, (m == 0) ? 32'h16 : (m == 1) ? 32'h06 : 32'h1A);
			u_cprr_fpga_model.init_pulse();
			ce_n <= 1'b0;
			if (m == 2)
			begin
				repeat (40) @(posedge clk_i);
				chk(sco_oe, 1'b0);
				rd(OFF_ADDR, 32'h20, 32'hFFF);
			end
			follow(1000, m == 1, m == 2, nr);
			chk(nr, 16);
			chk(sco_oe, 1'b0);
		end
		report_and_stop();
	end
endmodule

bind cprr_readout cprr_readout_monitor #(.BLOCK_LOG2(BLOCK_LOG2), .BLK_W(BLK_W)) u_cprr_readout_monitor (
	.clk_i, .reset_i, .mem_addr_o, .chip_enable_n_i, .output_enable_reset_i, .configuration_trigger_o,
	.configuration_trigger_oe_o, .data_o, .data_oe_o, .source_clock_output_o, .source_clock_output_oe_o,
	.chain_enable_output_n_o);
